/* core/sdl_top.sv */
`timescale 1ns/1ns
// serial load, latch and output control of a 16-bit serial-input converter
module sdl_top (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        chain_select,
    input  wire logic        frame_sync_n,
    input  wire logic        serial_clk,
    input  wire logic        serial_in,
    input  wire logic        latch_load_n,
    input  wire logic        zero_latch_n,
    input  wire logic        reset_request_n,
    input  wire logic        supply_good,
    output logic             serial_out,
    output logic             serial_out_oe,
    output logic [15:0]      dac_code,
    output logic             output_clamp_gate,
    output logic             amp_path_gate,
    output logic             supply_monitor_out_n
);
    sdl_pkg::sdl_pins_t  pins_in;
    sdl_pkg::sdl_pins_t  pins;
    sdl_pkg::sdl_edges_t edges;
    logic [15:0]         shift_reg;
    logic [15:0]         latch;
    logic [15:0]         held;
    logic [4:0]          bit_count;
    logic                auto_mode;
    logic                armed;
    logic                valid_word;

    assign pins_in = '{frame_n: frame_sync_n, sclk: serial_clk, sdata: serial_in,
                       load_n: latch_load_n, clear_n: zero_latch_n,
                       rst_req_n: reset_request_n, supply_ok: supply_good,
                       chain: chain_select};

    sdl_sync u_sync (
        .clk     (clk),
        .rst_b   (rst_b),
        .pins_in (pins_in),
        .pins    (pins),
        .edges   (edges)
    );

    // shift decode
    wire in_frame   = ~pins.frame_n & ~edges.frame_fall;
    wire gate_open  = pins.chain | (bit_count < sdl_pkg::FRAME_BITS);
    wire shift_now  = in_frame & edges.sclk_fall & gate_open;
    wire last_bit   = shift_now & ~pins.chain
                      & (bit_count == sdl_pkg::FRAME_BITS - 5'h01);
    wire next_msb   = shift_reg[sdl_pkg::WORD_W-1];
    wire auto_load  = last_bit & auto_mode;
    wire strobe_load = edges.load_fall & armed;
    wire do_clear   = ~pins.clear_n;
    wire do_load    = auto_load | strobe_load;
    wire [15:0] next_shift = {shift_reg[14:0], pins.sdata};
    wire [15:0] load_src   = auto_load ? next_shift : shift_reg;

    // shift register and frame bit counter
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_reg <= '0;
            bit_count <= '0;
        end else if (edges.frame_fall) begin
            bit_count <= '0;
        end else if (shift_now) begin
            shift_reg <= next_shift;
            if (bit_count != 5'h1f) begin
                bit_count <= bit_count + 5'h01;
            end
        end
    end

    // update mode caught at frame start; strobe armed once mode is strobed
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            auto_mode <= 1'b0;
            armed     <= 1'b0;
        end else if (edges.frame_fall) begin
            auto_mode <= ~pins.load_n;
            armed     <= pins.load_n;
        end
    end

    // converter latch: clear overrides load
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            latch <= sdl_pkg::LATCH_RESET;
        end else if (do_clear) begin
            latch <= '0;
        end else if (do_load) begin
            latch <= load_src;
        end
    end

    sdl_hold u_hold (
        .clk   (clk),
        .rst_b (rst_b),
        .start (strobe_load & ~do_clear),
        .latch (latch),
        .held  (held)
    );

    // valid word seen since last supply or reset-request drop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            valid_word <= 1'b0;
        end else if (!pins.supply_ok || !pins.rst_req_n) begin
            valid_word <= 1'b0;
        end else if (do_load) begin
            valid_word <= 1'b1;
        end
    end

    // registered outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dac_code             <= '0;
            output_clamp_gate    <= 1'b1;
            amp_path_gate        <= 1'b0;
            serial_out           <= 1'b0;
            serial_out_oe        <= 1'b0;
            supply_monitor_out_n <= 1'b0;
        end else begin
            dac_code             <= held;
            output_clamp_gate    <= ~valid_word;
            amp_path_gate        <= valid_word;
            serial_out           <= next_msb & pins.chain;
            serial_out_oe        <= pins.chain;
            supply_monitor_out_n <= pins.supply_ok;
        end
    end
endmodule // sdl_top

/* core/sdl_pkg.sv */
package sdl_pkg;
    localparam int unsigned WORD_W      = 16;
    localparam int unsigned CNT_W       = 5;
    localparam logic [4:0]  FRAME_BITS  = 5'h10;
    localparam logic [15:0] LATCH_RESET = 16'h0000;
    localparam int unsigned CLK_HZ      = 25000000;
    localparam int unsigned HOLD_NS     = 5000;
    // longest hold rounds down, at least one cycle
    localparam int unsigned HOLD_CYC_I  = (HOLD_NS * (CLK_HZ / 1000000)) / 1000;
    localparam int unsigned HOLD_CYC    = (HOLD_CYC_I < 1) ? 1 : HOLD_CYC_I;
    localparam int unsigned HOLD_W      = 8;
    localparam logic [7:0]  HOLD_LOAD   = 8'(HOLD_CYC);

    typedef struct packed {
        logic frame_n;
        logic sclk;
        logic sdata;
        logic load_n;
        logic clear_n;
        logic rst_req_n;
        logic supply_ok;
        logic chain;
    } sdl_pins_t;

    // synchroniser reset: frame and strobes idle high, supply not yet good
    localparam sdl_pins_t PINS_IDLE = '{frame_n: 1'b1, sclk: 1'b1, sdata: 1'b0,
                                        load_n: 1'b1, clear_n: 1'b1, rst_req_n: 1'b1,
                                        supply_ok: 1'b0, chain: 1'b0};

    typedef struct packed {
        logic sclk_fall;
        logic frame_fall;
        logic load_fall;
    } sdl_edges_t;
endpackage

/* core/sdl_sync.sv */
`timescale 1ns/1ns
// two-flop synchroniser for every pin input, plus edge detection on settled copies
module sdl_sync (
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire sdl_pkg::sdl_pins_t pins_in,
    output sdl_pkg::sdl_pins_t      pins,
    output sdl_pkg::sdl_edges_t     edges
);
    sdl_pkg::sdl_pins_t meta;
    sdl_pkg::sdl_pins_t prev;

    // idle levels: strobes high, supply not yet good
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= sdl_pkg::PINS_IDLE;
            pins <= sdl_pkg::PINS_IDLE;
            prev <= sdl_pkg::PINS_IDLE;
        end else begin
            meta <= pins_in;
            pins <= meta;
            prev <= pins;
        end
    end

    // falling edges seen on the second stage only
    assign edges.sclk_fall  = prev.sclk & ~pins.sclk;
    assign edges.frame_fall = prev.frame_n & ~pins.frame_n;
    assign edges.load_fall  = prev.load_n & ~pins.load_n;
endmodule // sdl_sync

/* core/sdl_hold.sv */
`timescale 1ns/1ns
// track-and-hold timer: output tracks latch except during hold window
module sdl_hold (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        start,
    input  wire logic [15:0] latch,
    output logic [15:0]      held
);
    logic [sdl_pkg::HOLD_W-1:0] count;
    wire  holding = (count != '0);

    // hold counter reloads on each strobed load
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
        end else if (start) begin
            count <= sdl_pkg::HOLD_LOAD;
        end else if (holding) begin
            count <= count - 1'b1;
        end
    end

    // tracked value, frozen while holding
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            held <= sdl_pkg::LATCH_RESET;
        end else if (!holding && !start) begin
            held <= latch;
        end
    end
endmodule // sdl_hold

/* testbench/sdl_host.sv */
`timescale 1ns/1ns
// host side of the serial link
module sdl_host (
    output logic frame_sync_n,
    output logic serial_clk,
    output logic serial_in
);
    // idle: frame high, clock parked high
    initial begin
        frame_sync_n = 1'b1;
        serial_clk   = 1'b1;
        serial_in    = 1'b0;
    end
    // one frame, top bit first, data set while clock high
    task automatic send(input logic [31:0] w, input logic [5:0] n);
        frame_sync_n = 1'b0;
        #160;
        for (int i = int'(n) - 1; i >= 0; i--) begin
            serial_in = w[i];
            #160 serial_clk = 1'b0;
            #160 serial_clk = 1'b1;
        end
        #160 frame_sync_n = 1'b1;
        serial_in = ~serial_in;
    endtask
    // free-running clock with frame high, data toggling; nothing may shift
    task automatic idle_clocks(input int n);
        repeat (n) begin
            #160 serial_clk = 1'b0;
            #160 serial_clk = 1'b1;
            serial_in = ~serial_in;
        end
    endtask
endmodule // sdl_host

/* testbench/sdl_top_asserts.sv */
`timescale 1ns/1ns
// port-level checks on the output control
module sdl_top_asserts (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        chain_select,
    input wire logic        latch_load_n,
    input wire logic        zero_latch_n,
    input wire logic        reset_request_n,
    input wire logic        supply_good,
    input wire logic        serial_out,
    input wire logic        serial_out_oe,
    input wire logic [15:0] dac_code,
    input wire logic        output_clamp_gate,
    input wire logic        amp_path_gate,
    input wire logic        supply_monitor_out_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // mode, clear, monitor, clamp and hold relations
    oe_on_a: assert property ($rose(chain_select) |-> ##[2:4] serial_out_oe)
        else $error("oe on late");
    oe_off_a: assert property ($fell(chain_select) |-> ##[2:4] !serial_out_oe)
        else $error("oe off late");
    so_quiet_a: assert property (!chain_select [*6] |-> !serial_out)
        else $error("serial out active");
    clr_zero_a: assert property (!zero_latch_n [*6] |-> dac_code == 16'h0000)
        else $error("clear not zero");
    mon_low_a: assert property (!supply_good [*5] |-> !supply_monitor_out_n)
        else $error("monitor high");
    sup_clamp_a: assert property (
        !supply_good [*5] |-> output_clamp_gate && !amp_path_gate)
        else $error("no supply clamp");
    req_clamp_a: assert property (
        !reset_request_n [*5] |-> output_clamp_gate && !amp_path_gate)
        else $error("no request clamp");
    out_hold_a: assert property (
        $fell(latch_load_n) && zero_latch_n |-> ##1 $stable(dac_code) [*8])
        else $error("hold broken");
endmodule // sdl_top_asserts
bind sdl_top sdl_top_asserts u_chk (
    .clk                  (clk),
    .rst_b                (rst_b),
    .chain_select         (chain_select),
    .latch_load_n         (latch_load_n),
    .zero_latch_n         (zero_latch_n),
    .reset_request_n      (reset_request_n),
    .supply_good          (supply_good),
    .serial_out           (serial_out),
    .serial_out_oe        (serial_out_oe),
    .dac_code             (dac_code),
    .output_clamp_gate    (output_clamp_gate),
    .amp_path_gate        (amp_path_gate),
    .supply_monitor_out_n (supply_monitor_out_n)
);

/* testbench/testbench.sv */
`timescale 1ns/1ns
module testbench;
    typedef struct packed {
        logic [31:0] word;
        logic [5:0]  nbits;
        logic [15:0] code;
    } sdl_row_t;
    logic        clk, rst_b, chain_select, latch_load_n;
    logic        zero_latch_n, reset_request_n, supply_good;
    logic        frame_sync_n, serial_clk, serial_in, serial_out, serial_out_oe;
    logic        output_clamp_gate, amp_path_gate, supply_monitor_out_n;
    logic [15:0] dac_code;
    int          n_fail, n_checks;
    sdl_row_t    rows [3] = '{'{32'h0000a5c3, 6'h10, 16'ha5c3},
                              '{32'h0001234f, 6'h14, 16'h1234},
                              '{32'h0000aaf0, 6'h10, 16'haaf0}};
    sdl_host host (.frame_sync_n(frame_sync_n), .serial_clk(serial_clk), .serial_in(serial_in));
    sdl_top dut (
        .clk                  (clk),
        .rst_b                (rst_b),
        .chain_select         (chain_select),
        .frame_sync_n         (frame_sync_n),
        .serial_clk           (serial_clk),
        .serial_in            (serial_in),
        .latch_load_n         (latch_load_n),
        .zero_latch_n         (zero_latch_n),
        .reset_request_n      (reset_request_n),
        .supply_good          (supply_good),
        .serial_out           (serial_out),
        .serial_out_oe        (serial_out_oe),
        .dac_code             (dac_code),
        .output_clamp_gate    (output_clamp_gate),
        .amp_path_gate        (amp_path_gate),
        .supply_monitor_out_n (supply_monitor_out_n)
    );
    // clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // watchdog
    initial begin
        #400000;
        n_fail++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        {chain_select, latch_load_n, rst_b} = 3'h0;
        {zero_latch_n, reset_request_n, supply_good} = 3'h7;
        cyc(20);
        rst_b = 1'b1;
        cyc(4);
        foreach (rows[i]) begin
            host.send(rows[i].word, rows[i].nbits);
            cyc(6);
            chk(dac_code, rows[i].code);
        end
        chk(16'({output_clamp_gate, amp_path_gate}), 16'h1);
        $display("auto done");
        latch_load_n = 1'b1;
        cyc(2);
        host.send(32'h5a5a, 6'h10);
        host.idle_clocks(4);
        cyc(6);
        chk(dac_code, 16'haaf0);
        latch_load_n = 1'b0;
        cyc(60);
        chk(dac_code, 16'haaf0);
        cyc(80);
        chk(dac_code, 16'h5a5a);
        $display("strobe done");
        {latch_load_n, chain_select} = 2'h3;
        cyc(6);
        host.send(32'h1111a222, 6'h20);
        cyc(6);
        chk(16'({serial_out_oe, serial_out}), 16'h3);
        latch_load_n = 1'b0;
        cyc(140);
        chk(dac_code, 16'ha222);
        chain_select = 1'b0;
        zero_latch_n = 1'b0;
        cyc(8);
        chk(dac_code, 16'h0);
        zero_latch_n = 1'b1;
        reset_request_n = 1'b0;
        cyc(8);
        chk(16'({output_clamp_gate, amp_path_gate}), 16'h2);
        reset_request_n = 1'b1;
        cyc(4);
        host.send(32'h0123, 6'h10);
        cyc(6);
        chk(16'({output_clamp_gate, amp_path_gate}), 16'h1);
        chk(dac_code, 16'h0123);
        supply_good = 1'b0;
        cyc(8);
        chk(16'({supply_monitor_out_n, output_clamp_gate}), 16'h1);
        $display("chain clear reset done");
        tally_and_finish();
    end
endmodule // testbench
